// ### rtl/sioc_pkg.sv
// constants and types of the stereo io conditioner
package sioc_pkg;

  // clock and sample-rate figures
  localparam int CLK_HZ = 40_000_000;
  localparam int FS_INT_HZ = 48_000;
  localparam int FS_MIN_HZ = 32_000;
  localparam int FS_MAX_HZ = 96_000;
  localparam int PERIOD_MIN_CYC = CLK_HZ / FS_MAX_HZ;
  localparam int PERIOD_MAX_CYC = (CLK_HZ + FS_MIN_HZ - 1) / FS_MIN_HZ;
  localparam int PERIOD_W = 11;
  localparam int PHASE_W = 26;
  localparam logic [PHASE_W-1:0] PHASE_INC = PHASE_W'(FS_INT_HZ);
  localparam logic [PHASE_W-1:0] PHASE_MOD = PHASE_W'(CLK_HZ);

  // gain format: unsigned, 14 fraction bits
  localparam int GAIN_FRAC = 14;
  localparam logic [15:0] GAIN_UNITY = 16'h4000;
  localparam logic [15:0] TRIM_MIN = 16'h2d4e;
  localparam logic [15:0] TRIM_MAX = 16'h5a67;

  // register byte offsets
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] IN_GAIN_OFF = 8'h04;
  localparam logic [7:0] IN_TRIM_OFF = 8'h10;
  localparam logic [7:0] OUT_GAIN_OFF = 8'h1c;
  localparam logic [7:0] OUT_TRIM_OFF = 8'h28;
  localparam logic [7:0] PRESET_OFF = 8'h34;
  localparam logic [7:0] STATUS_OFF = 8'h38;

  // field positions
  localparam int CTRL_BYPASS_BIT = 0;
  localparam int CTRL_INV_LSB = 1;
  localparam int CTRL_ROUTE_LSB = 3;
  localparam int CTRL_CLK_LSB = 6;
  localparam int PRESET_SAVE_BIT = 8;
  localparam int PRESET_LOAD_BIT = 9;
  localparam int STAT_LOCKED_BIT = 0;
  localparam int STAT_BYPASS_BIT = 1;
  localparam int STAT_ROOM_BIT = 2;
  localparam int STAT_SLOT_LSB = 8;

  typedef enum logic [1:0] {
    SIOC_INV_NONE, SIOC_INV_BOTH, SIOC_INV_LEFT, SIOC_INV_RIGHT
  } sioc_inv_e;

  typedef enum logic [2:0] {
    SIOC_RT_STEREO, SIOC_RT_MONO_L, SIOC_RT_MONO_R, SIOC_RT_MONO_SUM,
    SIOC_RT_SWAP
  } sioc_route_e;

  typedef enum logic [1:0] {
    SIOC_CLK_INTERNAL, SIOC_CLK_INPUT, SIOC_CLK_EXT
  } sioc_clk_e;

  typedef enum logic [1:0] {
    SIOC_SRC_ANALOG, SIOC_SRC_AES, SIOC_SRC_NET
  } sioc_src_e;

  // one complete set of io settings, also the preset word
  typedef struct packed {
    logic bypass;
    sioc_inv_e inv;
    sioc_route_e route;
    sioc_clk_e clk_src;
    logic [2:0][15:0] in_gain;
    logic [2:0][15:0] in_trim;
    logic [2:0][15:0] out_gain;
    logic [2:0][15:0] out_trim;
  } sioc_cfg_s;

  localparam sioc_cfg_s CFG_RESET = '{
    bypass: 1'b0, inv: SIOC_INV_NONE, route: SIOC_RT_STEREO,
    clk_src: SIOC_CLK_INTERNAL,
    in_gain: {3{GAIN_UNITY}}, in_trim: {3{GAIN_UNITY}},
    out_gain: {3{GAIN_UNITY}}, out_trim: {3{GAIN_UNITY}}};

endpackage

// ### rtl/sioc_fifo.sv
// frame fifo with valid/ready on both sides
`timescale 1ns/1ps
module sioc_fifo #(
  parameter int WIDTH = 50,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // filling side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // draining side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_chk
    $error("sioc_fifo: depth must be a power of two, width positive");
  end

  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
    logic room;
  } sioc_fifo_s;

  sioc_fifo_s r_reg, r_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push, pop;
  logic [AW:0] fill;

  assign push = in_valid_i && r_reg.room;
  assign pop = out_valid_o && out_ready_i;
  assign in_ready_o = r_reg.room;
  assign out_valid_o = (r_reg.wp != r_reg.rp);
  assign out_data_o = mem[r_reg.rp[AW-1:0]];

  always_comb begin
    r_next = r_reg;
    if (push) begin
      r_next.wp = r_reg.wp + 1'b1;
    end
    if (pop) begin
      r_next.rp = r_reg.rp + 1'b1;
    end
    fill = r_next.wp - r_next.rp;
    // registered so the filling side sees back-pressure from a flop
    r_next.room = (fill != (AW+1)'(DEPTH));
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_reg <= '{wp: '0, rp: '0, room: 1'b1};
    end else begin
      r_reg <= r_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[r_reg.wp[AW-1:0]] <= in_data_i;
    end
  end
endmodule

// ### rtl/sioc_top.sv
// stereo io conditioner: input trims, inversion, routing, output trims
//
// Added by the designer: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
module sioc_top #(
  parameter int SW = 24,
  parameter int FIFO_DEPTH = 32,
  parameter int PRESETS = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone register slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // selected input source frames
  input wire logic src_valid_i,
  output logic src_ready_o,
  input wire sioc_pkg::sioc_src_e src_sel_i,
  input wire logic signed [SW-1:0] src_left_i,
  input wire logic signed [SW-1:0] src_right_i,
  // frames into the processing chain
  output logic proc_valid_o,
  input wire logic proc_ready_i,
  output logic signed [SW-1:0] proc_left_o,
  output logic signed [SW-1:0] proc_right_o,
  // frames back from the processing chain
  input wire logic ret_valid_i,
  input wire logic signed [SW-1:0] ret_left_i,
  input wire logic signed [SW-1:0] ret_right_i,
  // conditioned outputs
  output logic out_valid_o,
  output logic signed [SW-1:0] ana_left_o,
  output logic signed [SW-1:0] ana_right_o,
  output logic signed [SW-1:0] aes_left_o,
  output logic signed [SW-1:0] aes_right_o,
  output logic signed [SW-1:0] net_left_o,
  output logic signed [SW-1:0] net_right_o,
  // sample-rate clock pins and result
  input wire logic aes_wclk_i,
  input wire logic sync_wclk_i,
  output logic fs_tick_o,
  output logic rate_locked_o
);
  import sioc_pkg::*;

  localparam int SLOT_W = (PRESETS > 1) ? $clog2(PRESETS) : 1;
  localparam int FW = 2 * SW + 2;

  if (SW < 8 || SW > 32 || PRESETS < 1 || PRESETS > 256) begin : g_chk
    $error("sioc_top: unsupported sample width or preset count");
  end

  typedef struct packed {
    sioc_cfg_s cfg;
    sioc_cfg_s [PRESETS-1:0] bank;
    logic [SLOT_W-1:0] last_slot;
    logic ack;
    logic [31:0] rdata;
    logic act_bypass;
    sioc_inv_e act_inv;
    sioc_route_e act_route;
    logic pvalid;
    logic signed [SW-1:0] pl;
    logic signed [SW-1:0] pr;
    logic ovalid;
    logic signed [2:0][SW-1:0] ol;
    logic signed [2:0][SW-1:0] orr;
    logic [2:0] aes_sync;
    logic [2:0] ext_sync;
    logic aes_filt;
    logic ext_filt;
    logic [PHASE_W-1:0] phase;
    logic [PERIOD_W-1:0] period;
    logic locked;
    logic fs_tick;
  } sioc_state_s;

  sioc_state_s r_reg, r_next;

  logic fifo_valid, fifo_ready, pop;
  logic [FW-1:0] fifo_data;
  logic [1:0] f_sel;
  logic signed [SW-1:0] f_l, f_r, l1, r1, l2, r2, sum;
  logic [1:0] gi;
  logic [31:0] bmask, rd_word, wd;
  logic [SLOT_W-1:0] slot;
  logic int_tick, aes_edge, ext_edge, sel_edge;

  // saturating gain multiply, 14 fraction bits
  function automatic logic signed [SW-1:0] scale(
    input logic signed [SW-1:0] s, input logic [15:0] g);
    logic signed [SW+16:0] p;
    logic signed [SW+16:0] q;
    p = s * $signed({1'b0, g});
    q = p >>> GAIN_FRAC;
    scale = (q[SW+16:SW-1] == '0 || q[SW+16:SW-1] == '1) ? q[SW-1:0] :
      q[SW+16] ? {1'b1, {(SW-1){1'b0}}} : {1'b0, {(SW-1){1'b1}}};
  endfunction

  // saturate a value one bit wider than a sample
  function automatic logic signed [SW-1:0] sat1(
    input logic signed [SW:0] v);
    sat1 = (v[SW] == v[SW-1]) ? v[SW-1:0] :
      v[SW] ? {1'b1, {(SW-1){1'b0}}} : {1'b0, {(SW-1){1'b1}}};
  endfunction

  // negation saturates so the most negative code cannot wrap
  function automatic logic signed [SW-1:0] neg(
    input logic signed [SW-1:0] s);
    neg = sat1(-{s[SW-1], s});
  endfunction

  function automatic logic [15:0] clamp_trim(input logic [15:0] t);
    clamp_trim = (t < TRIM_MIN) ? TRIM_MIN : (t > TRIM_MAX) ? TRIM_MAX : t;
  endfunction

  sioc_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(src_valid_i),
    .in_ready_o(fifo_ready),
    .in_data_i({src_sel_i, src_left_i, src_right_i}),
    .out_valid_o(fifo_valid),
    .out_ready_i(pop),
    .out_data_o(fifo_data)
  );

  // bypass drains freely; processing waits for the chain to take a frame
  assign pop = fifo_valid && (r_reg.act_bypass || !r_reg.pvalid ||
                              proc_ready_i);
  assign f_sel = fifo_data[FW-1 -: 2];
  assign f_l = $signed(fifo_data[2*SW-1 -: SW]);
  assign f_r = $signed(fifo_data[SW-1:0]);
  // an unused source code falls back to the analog settings
  assign gi = (f_sel == 2'h3) ? 2'h0 : f_sel;
  assign bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                  {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign slot = wb_dat_i[SLOT_W-1:0];

  // input level, trim, inversion and routing of one frame
  always_comb begin
    l1 = scale(f_l, r_reg.cfg.in_gain[gi]);
    r1 = scale(scale(f_r, r_reg.cfg.in_gain[gi]),
               r_reg.cfg.in_trim[gi]);
    case (r_reg.act_inv)
      SIOC_INV_BOTH: {l1, r1} = {neg(l1), neg(r1)};
      SIOC_INV_LEFT: l1 = neg(l1);
      SIOC_INV_RIGHT: r1 = neg(r1);
      default: ;
    endcase
    sum = sat1({l1[SW-1], l1} + {r1[SW-1], r1});
    // source code only picks gains and trims, routing is the same for any source
    case (r_reg.act_route)
      SIOC_RT_MONO_L: {l2, r2} = {l1, l1};
      SIOC_RT_MONO_R: {l2, r2} = {r1, r1};
      SIOC_RT_MONO_SUM: {l2, r2} = {sum, sum};
      SIOC_RT_SWAP: {l2, r2} = {r1, l1};
      default: {l2, r2} = {l1, r1};
    endcase
  end

  // register read mux
  always_comb begin
    rd_word = 32'h0000_0000;
    if (wb_adr_i == CTRL_OFF) begin
      rd_word[CTRL_BYPASS_BIT] = r_reg.cfg.bypass;
      rd_word[CTRL_INV_LSB +: 2] = r_reg.cfg.inv;
      rd_word[CTRL_ROUTE_LSB +: 3] = r_reg.cfg.route;
      rd_word[CTRL_CLK_LSB +: 2] = r_reg.cfg.clk_src;
    end else if (wb_adr_i == PRESET_OFF) begin
      rd_word[SLOT_W-1:0] = r_reg.last_slot;
    end else if (wb_adr_i == STATUS_OFF) begin
      rd_word[STAT_LOCKED_BIT] = r_reg.locked;
      rd_word[STAT_BYPASS_BIT] = r_reg.act_bypass;
      rd_word[STAT_ROOM_BIT] = fifo_ready;
      rd_word[STAT_SLOT_LSB +: SLOT_W] = r_reg.last_slot;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (wb_adr_i == IN_GAIN_OFF + 8'(4 * i)) begin
          rd_word[15:0] = r_reg.cfg.in_gain[i];
        end else if (wb_adr_i == IN_TRIM_OFF + 8'(4 * i)) begin
          rd_word[15:0] = r_reg.cfg.in_trim[i];
        end else if (wb_adr_i == OUT_GAIN_OFF + 8'(4 * i)) begin
          rd_word[15:0] = r_reg.cfg.out_gain[i];
        end else if (wb_adr_i == OUT_TRIM_OFF + 8'(4 * i)) begin
          rd_word[15:0] = r_reg.cfg.out_trim[i];
        end
      end
    end
  end

  always_comb begin
    r_next = r_reg;
    wd = (rd_word & ~bmask) | (wb_dat_i & bmask);
    r_next.ack = 1'b0;
    // classic wishbone: answer one cycle after the strobe, then drop
    if (wb_cyc_i && wb_stb_i && !r_reg.ack) begin
      r_next.ack = 1'b1;
      r_next.rdata = rd_word;
      if (wb_we_i) begin
        if (wb_adr_i == CTRL_OFF) begin
          r_next.cfg.bypass = wd[CTRL_BYPASS_BIT];
          r_next.cfg.inv = sioc_inv_e'(wd[CTRL_INV_LSB +: 2]);
          r_next.cfg.route = sioc_route_e'(wd[CTRL_ROUTE_LSB +: 3]);
          r_next.cfg.clk_src = sioc_clk_e'(wd[CTRL_CLK_LSB +: 2]);
        end else if (wb_adr_i == PRESET_OFF && wb_sel_i[1]) begin
          if (wb_dat_i[PRESET_SAVE_BIT]) begin
            r_next.bank[slot] = r_reg.cfg;
            r_next.last_slot = slot;
          end else if (wb_dat_i[PRESET_LOAD_BIT]) begin
            r_next.cfg = r_reg.bank[slot];
            r_next.last_slot = slot;
          end
        end else begin
          for (int i = 0; i < 3; i++) begin
            if (wb_adr_i == IN_GAIN_OFF + 8'(4 * i)) begin
              r_next.cfg.in_gain[i] = wd[15:0];
            end else if (wb_adr_i == IN_TRIM_OFF + 8'(4 * i)) begin
              r_next.cfg.in_trim[i] = clamp_trim(wd[15:0]);
            end else if (wb_adr_i == OUT_GAIN_OFF + 8'(4 * i)) begin
              r_next.cfg.out_gain[i] = wd[15:0];
            end else if (wb_adr_i == OUT_TRIM_OFF + 8'(4 * i)) begin
              r_next.cfg.out_trim[i] = clamp_trim(wd[15:0]);
            end
          end
        end
      end
    end

    // frame path
    if (r_reg.pvalid && proc_ready_i) begin
      r_next.pvalid = 1'b0;
    end
    r_next.ovalid = 1'b0;
    if (pop) begin
      if (r_reg.act_bypass) begin
        r_next.ovalid = 1'b1;
        for (int k = 0; k < 3; k++) begin
          r_next.ol[k] = f_l;
          r_next.orr[k] = f_r;
        end
      end else begin
        r_next.pvalid = 1'b1;
        r_next.pl = l2;
        r_next.pr = r2;
      end
    end else begin
      // both samples of a frame share one snapshot of the settings
      r_next.act_bypass = r_reg.cfg.bypass;
      r_next.act_inv = r_reg.cfg.inv;
      r_next.act_route = r_reg.cfg.route;
    end
    if (!r_reg.act_bypass && ret_valid_i) begin
      r_next.ovalid = 1'b1;
      // k = 0 analog, 1 aes, 2 network
      for (int k = 0; k < 3; k++) begin
        r_next.ol[k] = scale(ret_left_i, r_reg.cfg.out_gain[k]);
        r_next.orr[k] = scale(scale(ret_right_i, r_reg.cfg.out_gain[k]),
                              r_reg.cfg.out_trim[k]);
      end
    end

    // word clock pins: three flops, a change counts when two agree
    r_next.aes_sync = {r_reg.aes_sync[1:0], aes_wclk_i};
    r_next.ext_sync = {r_reg.ext_sync[1:0], sync_wclk_i};
    if (r_reg.aes_sync[1] == r_reg.aes_sync[2]) begin
      r_next.aes_filt = r_reg.aes_sync[2];
    end
    if (r_reg.ext_sync[1] == r_reg.ext_sync[2]) begin
      r_next.ext_filt = r_reg.ext_sync[2];
    end
    aes_edge = r_next.aes_filt && !r_reg.aes_filt;
    ext_edge = r_next.ext_filt && !r_reg.ext_filt;

    // fractional divider keeps the mean rate exact at 48 kHz
    int_tick = 1'b0;
    r_next.phase = r_reg.phase + PHASE_INC;
    if (r_next.phase >= PHASE_MOD) begin
      r_next.phase = r_next.phase - PHASE_MOD;
      int_tick = 1'b1;
    end
    case (r_reg.cfg.clk_src)
      SIOC_CLK_INPUT: sel_edge = aes_edge;
      SIOC_CLK_EXT: sel_edge = ext_edge;
      default: sel_edge = int_tick;
    endcase
    r_next.fs_tick = sel_edge;

    // word clock pins lock only while the period lies in the served rate range; internal always locks
    if (r_reg.cfg.clk_src == SIOC_CLK_INTERNAL) begin
      r_next.locked = 1'b1;
      r_next.period = '0;
    end else if (sel_edge) begin
      r_next.locked = (r_reg.period >= PERIOD_W'(PERIOD_MIN_CYC - 1)) &&
                      (r_reg.period <= PERIOD_W'(PERIOD_MAX_CYC - 1));
      r_next.period = '0;
    end else if (r_reg.period != PERIOD_W'(PERIOD_MAX_CYC)) begin
      r_next.period = r_reg.period + 1'b1;
    end else begin
      r_next.locked = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_reg <= '0;
      r_reg.cfg <= CFG_RESET;
      r_reg.bank <= {PRESETS{CFG_RESET}};
      r_reg.locked <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign wb_ack_o = r_reg.ack;
  assign wb_dat_o = r_reg.rdata;
  assign src_ready_o = fifo_ready;
  assign proc_valid_o = r_reg.pvalid;
  assign proc_left_o = r_reg.pl;
  assign proc_right_o = r_reg.pr;
  assign out_valid_o = r_reg.ovalid;
  assign ana_left_o = r_reg.ol[0];
  assign ana_right_o = r_reg.orr[0];
  assign aes_left_o = r_reg.ol[1];
  assign aes_right_o = r_reg.orr[1];
  assign net_left_o = r_reg.ol[2];
  assign net_right_o = r_reg.orr[2];
  assign fs_tick_o = r_reg.fs_tick;
  assign rate_locked_o = r_reg.locked;
endmodule

// ### bench/sioc_props.sv
// assertion checker on the conditioner's ports
`timescale 1ns/1ps
module sioc_props #(
  parameter int SW = 24
) (
  // clock, reset and bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // streams and rate
  input wire logic src_ready_o,
  input wire logic proc_valid_o,
  input wire logic proc_ready_i,
  input wire logic [SW-1:0] proc_left_o,
  input wire logic [SW-1:0] proc_right_o,
  input wire logic out_valid_o,
  input wire logic [SW-1:0] ana_left_o,
  input wire logic [SW-1:0] ana_right_o,
  input wire logic [SW-1:0] aes_left_o,
  input wire logic [SW-1:0] aes_right_o,
  input wire logic [SW-1:0] net_left_o,
  input wire logic [SW-1:0] net_right_o,
  input wire logic fs_tick_o,
  input wire logic rate_locked_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic req;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  property p_ack_taken;
    req |=> wb_ack_o;
  endproperty
  a_ack_taken: assert property (p_ack_taken) else $error("ack late");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack stuck");
  property p_ack_idle;
    !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o;
  endproperty
  a_ack_idle: assert property (p_ack_idle) else $error("stray ack");
  property p_unmapped;
    req && !wb_we_i && wb_adr_i == 8'hfc |=> wb_dat_o == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped data");
  property p_proc_hold;
    proc_valid_o && !proc_ready_i |=> proc_valid_o && $stable(proc_left_o)
      && $stable(proc_right_o);
  endproperty
  a_proc_hold: assert property (p_proc_hold) else $error("frame torn");
  property p_out_hold;
    !out_valid_o |-> $stable({ana_left_o, ana_right_o, aes_left_o,
      aes_right_o, net_left_o, net_right_o});
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("output moved");
  property p_tick_gap;
    fs_tick_o |=> !fs_tick_o [*3];
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("tick too long");
  property p_reset;
    disable iff (1'b0) rst_i |=> !wb_ack_o && !proc_valid_o && !out_valid_o
      && rate_locked_o && src_ready_o && wb_dat_o == 32'h0000_0000;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state");
endmodule

// ### bench/sioc_chain_model.sv
// processing chain stand-in: returns each frame unchanged
`timescale 1ns/1ps
module sioc_chain_model #(
  parameter int SW = 24
) (
  // clock, reset and pacing
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic stall_i,
  input wire logic slow_i,
  // frames in
  input wire logic proc_valid_i,
  output logic proc_ready_o,
  input wire logic signed [SW-1:0] proc_left_i,
  input wire logic signed [SW-1:0] proc_right_i,
  // frames back
  output logic ret_valid_o,
  output logic signed [SW-1:0] ret_left_o,
  output logic signed [SW-1:0] ret_right_o
);
  logic [1:0] cnt;
  always_ff @(posedge clk_i) begin
    cnt <= rst_i ? 2'h0 : cnt + 2'h1;
    proc_ready_o <= !rst_i && !stall_i && (!slow_i || cnt == 2'h3);
    ret_valid_o <= !rst_i && proc_valid_i && proc_ready_o;
    if (proc_valid_i && proc_ready_o) begin
      ret_left_o <= proc_left_i;
      ret_right_o <= proc_right_i;
    end else begin
      ret_left_o <= ~ret_left_o;
      ret_right_o <= ~ret_right_o;
    end
  end
endmodule

// ### bench/sioc_top_test.sv
// self-checking bench for the stereo io conditioner
`timescale 1ns/1ps
module sioc_top_test;
  import sioc_pkg::*;
  localparam int SW = 24;
  localparam logic signed [SW-1:0] SMAX = 24'sh7f_ffff;
  localparam logic signed [SW-1:0] SMIN = 24'sh80_0000;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, stall, slow;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic src_valid_i, src_ready_o, proc_valid_o, proc_ready_i, ret_valid_i;
  logic out_valid_o, aes_wclk_i, sync_wclk_i, fs_tick_o, rate_locked_o, pon;
  sioc_src_e src_sel_i;
  logic signed [SW-1:0] src_left_i, src_right_i, proc_left_o, proc_right_o;
  logic signed [SW-1:0] ret_left_i, ret_right_i, ana_left_o, ana_right_o;
  logic signed [SW-1:0] aes_left_o, aes_right_o, net_left_o, net_right_o;
  logic signed [SW-1:0] cl, cr;
  logic [47:0] qp[$];
  logic [143:0] qo[$];
  logic [15:0] ig[3], it[3], og[3], ot[3];
  int errors, num_checks, seed, inv, rt, pc, cs, g, n, k;
  bit byp;

  sioc_top i_sioc_top (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .src_valid_i,
    .src_ready_o, .src_sel_i, .src_left_i, .src_right_i, .proc_valid_o,
    .proc_ready_i, .proc_left_o, .proc_right_o, .ret_valid_i, .ret_left_i,
    .ret_right_i, .out_valid_o, .ana_left_o, .ana_right_o, .aes_left_o,
    .aes_right_o, .net_left_o, .net_right_o, .aes_wclk_i, .sync_wclk_i,
    .fs_tick_o, .rate_locked_o);
  sioc_chain_model i_sioc_chain_model (.clk_i, .rst_i, .stall_i(stall),
    .slow_i(slow), .proc_valid_i(proc_valid_o), .proc_ready_o(proc_ready_i),
    .proc_left_i(proc_left_o), .proc_right_i(proc_right_o),
    .ret_valid_o(ret_valid_i), .ret_left_o(ret_left_i),
    .ret_right_o(ret_right_i));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    pc <= (!pon || pc >= 999) ? 0 : pc + 1;
    aes_wclk_i <= pon && (pc % 500) < 250;
    sync_wclk_i <= pon && pc < 500;
  end

  function automatic logic signed [SW-1:0] sat(logic signed [47:0] v);
    if (v > SMAX) return SMAX;
    if (v < SMIN) return SMIN;
    return v[SW-1:0];
  endfunction
  function automatic logic signed [SW-1:0] mul(logic signed [SW-1:0] s,
      logic [15:0] q);
    return sat((48'(s) * $signed({32'h0000_0000, q})) >>> 14);
  endfunction
  function automatic logic [47:0] fproc(int s, logic signed [SW-1:0] l, r);
    logic signed [SW-1:0] a, b, m;
    a = mul(l, ig[s]);
    b = mul(mul(r, ig[s]), it[s]);
    if (inv == 1 || inv == 2) a = sat(-48'(a));
    if (inv == 1 || inv == 3) b = sat(-48'(b));
    m = sat(48'(a) + 48'(b));
    case (rt)
      1: return {a, a};
      2: return {b, b};
      3: return {m, m};
      4: return {b, a};
      default: return {a, b};
    endcase
  endfunction
  function automatic logic [143:0] fout(logic signed [SW-1:0] l, r);
    logic [143:0] o;
    for (int d = 0; d < 3; d++)
      o[143-48*d -: 48] = {mul(l, og[d]), mul(mul(r, og[d]), ot[d])};
    return o;
  endfunction

  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk_reg(input logic [31:0] e, a);
    chk_frm(144'(e), 144'(a));
  endtask
  task automatic chk_frm(input logic [143:0] e, a);
    num_checks++;
    if (a !== e) begin
      errors++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, a);
    end
  endtask
  task automatic tmo(input bit bad);
    if (bad) begin
      errors++;
      $display("[FAIL] t=%0t wait ran out exp=1 got=0", $time);
      complete_run();
    end
  endtask
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
      input logic [3:0] s, output logic [31:0] q);
    int m;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    m = 0;
    do begin
      @(posedge clk_i);
      m++;
    end while (wb_ack_o !== 1'b1 && m < 50);
    tmo(wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(a, 1'b1, d, 4'hf, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(a, 1'b0, 32'h0000_0000, 4'hf, q);
    chk_reg(e, q);
  endtask
  task automatic pick();
    cs = {$random(seed)} % 3;
    cl = SW'(($random(seed) % 128) * 32768);
    cr = SW'(($random(seed) % 128) * 32768);
    src_sel_i <= sioc_src_e'(cs);
    src_left_i <= cl;
    src_right_i <= cr;
    src_valid_i <= 1'b1;
  endtask
  task automatic note();
    logic [47:0] p;
    p = fproc(cs, cl, cr);
    if (byp) qo.push_back({3{cl, cr}});
    else begin
      qp.push_back(p);
      qo.push_back(fout(p[47:24], p[23:0]));
    end
  endtask
  task automatic burst(input int c);
    int m;
    for (int i = 0; i < c; i++) begin
      pick();
      note();
      m = 0;
      do begin
        @(posedge clk_i);
        m++;
      end while (src_ready_o !== 1'b1 && m < 500);
      tmo(src_ready_o !== 1'b1);
    end
    src_valid_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic drain();
    int m;
    m = 0;
    while (qp.size() + qo.size() > 0 && m < 3000) begin
      @(posedge clk_i);
      m++;
    end
    tmo(m >= 3000);
    repeat (2) @(posedge clk_i);
  endtask
  task automatic tick_gap(output int q);
    int m;
    for (int j = 0; j < 3; j++) begin
      m = 0;
      do begin
        @(posedge clk_i);
        m++;
      end while (fs_tick_o !== 1'b1 && m < 3000);
      tmo(fs_tick_o !== 1'b1);
    end
    q = m;
  endtask

  always @(posedge clk_i) begin
    if (rst_i === 1'b0 && proc_valid_o === 1'b1 && proc_ready_i === 1'b1)
      chk_frm(qp.size() > 0 ? 144'(qp.pop_front()) : 'x,
        144'({proc_left_o, proc_right_o}));
    if (rst_i === 1'b0 && out_valid_o === 1'b1)
      chk_frm(qo.size() > 0 ? qo.pop_front() : 'x, {ana_left_o, ana_right_o,
        aes_left_o, aes_right_o, net_left_o, net_right_o});
  end

  initial begin
    seed = 89917;
    {wb_cyc_i, wb_stb_i, wb_we_i, src_valid_i, stall, slow, pon, byp} = '0;
    {wb_adr_i, wb_sel_i, wb_dat_i, src_left_i, src_right_i} = '0;
    src_sel_i = SIOC_SRC_ANALOG;
    for (int i = 0; i < 3; i++) {ig[i], it[i], og[i], ot[i]} = {4{GAIN_UNITY}};
    rst_i = 1'b1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(CTRL_OFF, 32'h0000_0000);
    rd(IN_GAIN_OFF, 32'h0000_4000);
    rd(8'hfc, 32'h0000_0000);
    wr(IN_GAIN_OFF + 8'h08, 32'h0000_8000);
    wr(IN_TRIM_OFF + 8'h08, 32'h0000_ffff);
    rd(IN_TRIM_OFF + 8'h08, 32'(TRIM_MAX));
    {ig[2], it[2]} = {16'h8000, TRIM_MAX};
    $display("registers done");
    for (int r = 0; r < 5; r++)
      for (int v = 0; v < 4; v++) begin
        {rt, inv} = {r, v};
        slow <= v % 2;
        wr(CTRL_OFF, 32'((r << 3) | (v << 1)));
        burst(4);
        drain();
      end
    $display("routing done");
    {rt, inv, k, n} = '0;
    wr(CTRL_OFF, 32'h0000_0000);
    stall <= 1'b1;
    pick();
    while (k < 4 && n < 40) begin
      @(posedge clk_i);
      if (src_ready_o === 1'b1) begin
        note();
        n++;
        k = 0;
        pick();
      end else k++;
    end
    src_valid_i <= 1'b0;
    chk_reg(32'(n >= 32), 32'h0000_0001);
    rd(STATUS_OFF, 32'h0000_0001);
    stall <= 1'b0;
    drain();
    $display("fifo done");
    wr(IN_GAIN_OFF + 8'h08, 32'(GAIN_UNITY));
    wr(IN_TRIM_OFF + 8'h08, 32'(GAIN_UNITY));
    wr(OUT_GAIN_OFF, 32'h0000_2000);
    wr(OUT_TRIM_OFF, 32'h0000_0000);
    wr(OUT_GAIN_OFF + 8'h04, 32'h0000_8000);
    wr(OUT_TRIM_OFF + 8'h04, 32'h0000_ffff);
    rd(OUT_TRIM_OFF, 32'(TRIM_MIN));
    {ig[2], it[2], og[0], ot[0]} = {GAIN_UNITY, GAIN_UNITY, 16'h2000, TRIM_MIN};
    {og[1], ot[1]} = {16'h8000, TRIM_MAX};
    burst(8);
    drain();
    $display("outputs done");
    wr(CTRL_OFF, 32'h0000_0023);
    byp = 1'b1;
    rd(STATUS_OFF, 32'h0000_0007);
    burst(6);
    drain();
    byp = 1'b0;
    wr(CTRL_OFF, 32'h0000_0000);
    $display("bypass done");
    wr(IN_GAIN_OFF, 32'h0000_1234);
    wr(PRESET_OFF, 32'h0000_0103);
    wr(IN_GAIN_OFF, 32'h0000_4000);
    wr(PRESET_OFF, 32'h0000_0203);
    rd(IN_GAIN_OFF, 32'h0000_1234);
    rd(PRESET_OFF, 32'h0000_0003);
    $display("presets done");
    tick_gap(g);
    chk_reg(32'(g == 833 || g == 834), 32'h0000_0001);
    pon <= 1'b1;
    wr(CTRL_OFF, 32'h0000_0040);
    tick_gap(g);
    chk_reg(32'(g), 32'h0000_01f4);
    wr(CTRL_OFF, 32'h0000_0080);
    tick_gap(g);
    chk_reg(32'(g), 32'h0000_03e8);
    chk_reg(32'(rate_locked_o), 32'h0000_0001);
    pon <= 1'b0;
    repeat (1300) @(posedge clk_i);
    chk_reg(32'(rate_locked_o), 32'h0000_0000);
    $display("rates done");
    complete_run();
  end
endmodule

bind sioc_top sioc_props #(.SW(SW)) i_sioc_props (.clk_i, .rst_i, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .src_ready_o,
  .proc_valid_o, .proc_ready_i, .proc_left_o, .proc_right_o, .out_valid_o,
  .ana_left_o, .ana_right_o, .aes_left_o, .aes_right_o, .net_left_o,
  .net_right_o, .fs_tick_o, .rate_locked_o);
